//--- pkg/lps_pkg.sv
// lps_pkg: constants and types of the low power supervisor sequencer
// ----------------------------------------------------------------------
// Behaviour
// - over-current flags fault only with current monitoring fitted, halts transfer one minute
// - metal and object detection need current monitoring
// - supervisor presence read from pulled-up strap
// - present supervisor gets embedded firmware at cold start, kept state on other wakes
// - standby sends a present supervisor one sleep request, then stays asleep
// - wake every 400 ms for analog ping, only in standby with no supervisor present
// - drive three half-bridges, only one at a time, one coil each
// - feedback chain follows the coil being driven
// ----------------------------------------------------------------------
package lps_pkg;
  // clock and timing
  localparam int unsigned CLK_HZ = 200000000;
  localparam int unsigned OC_HOLD_S = 60;
  localparam int unsigned PING_MS = 400;
  localparam longint unsigned OC_HOLD_CYC = longint'(OC_HOLD_S) * longint'(CLK_HZ);
  localparam longint unsigned PING_CYC = longint'(PING_MS) * longint'(CLK_HZ) / 1000;
  localparam int unsigned TMR_W = 36;
  // coils and firmware image
  localparam int unsigned N_COILS = 3;
  localparam int unsigned FW_WORDS = 16;
  localparam int unsigned FW_IDX_W = 4;
  // reset values
  localparam logic [1:0] CHARGE_RST = 2'h0;
  localparam logic [1:0] MODE_RST = 2'h0;
  // sequencer states
  typedef enum logic [2:0] {
    ST_STRAP, ST_BOOT, ST_RESTORE, ST_RUN, ST_FAULT, ST_SLEEP
  } lps_state_e;
endpackage : lps_pkg

//--- core/lps_seq.sv
// lps_seq: standby sequencing, over-current hold and coil steering
module lps_seq import lps_pkg::*; #(
  parameter longint unsigned OC_HOLD_CYCLES = OC_HOLD_CYC,
  parameter longint unsigned PING_CYCLES = PING_CYC
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  // presence and cold start straps used at reset release, current monitor input read continuously
  input wire logic strap_sup_i,
  input wire logic cold_start_i,
  input wire logic cur_mon_present_i,
  // current supervision and detection enables
  input wire logic oc_over_i,
  input wire logic pmd_req_i,
  input wire logic fod_req_i,
  output logic parasitic_metal_detect_en_o,
  output logic foreign_object_detect_en_o,
  output logic fault_o,
  // supervisor link
  output logic sup_present_o,
  output logic fw_valid_o,
  output logic [7:0] fw_data_o,
  input wire logic fw_ready_i,
  output logic sleep_req_o,
  input wire logic ret_valid_i,
  input wire logic [1:0] ret_charge_i,
  input wire logic [1:0] ret_mode_i,
  input wire logic ret_fault_i,
  // operating state
  input wire logic standby_i,
  input wire logic [1:0] charge_i,
  input wire logic [1:0] mode_i,
  output logic [1:0] charge_o,
  output logic [1:0] mode_o,
  output logic ready_o,
  output logic ping_o,
  // power stages and feedback mux
  input wire logic drive_i,
  input wire logic [1:0] coil_i,
  output logic [N_COILS-1:0] hb_en_o,
  output logic [N_COILS-1:0] fb_sel_o
);
  // embedded supervisor image, fixed at build time
  localparam logic [7:0] FW_IMAGE [FW_WORDS] = '{
    8'h3C, 8'hA5, 8'h01, 8'h7E, 8'h40, 8'h12, 8'h9B, 8'h00,
    8'hC3, 8'h5A, 8'h22, 8'hE1, 8'h08, 8'h77, 8'hF0, 8'h0F};
  localparam logic [TMR_W-1:0] OC_LOAD = TMR_W'(OC_HOLD_CYCLES - 1);
  localparam logic [TMR_W-1:0] PING_LOAD = TMR_W'(PING_CYCLES - 1);

  lps_state_e state_q, state_d;
  logic [TMR_W-1:0] tmr_q;
  logic [FW_IDX_W-1:0] fw_idx_q;
  logic fw_acc, oc_trip, ping_due;
  logic [N_COILS-1:0] coil_oh;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  assign fw_acc = fw_valid_o && fw_ready_i;
  assign oc_trip = oc_over_i && cur_mon_present_i;
  assign ping_due = standby_i && !sup_present_o && (tmr_q == '0);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_STRAP: begin
        if (strap_sup_i && cold_start_i) state_d = ST_BOOT;
        else if (strap_sup_i) state_d = ST_RESTORE;
        else state_d = ST_RUN;
      end
      ST_BOOT: begin
        if (fw_acc && fw_idx_q == FW_IDX_W'(FW_WORDS - 1)) state_d = ST_RUN;
      end
      ST_RESTORE: begin
        if (ret_valid_i) state_d = ret_fault_i ? ST_FAULT : ST_RUN;
      end
      ST_RUN: begin
        if (oc_trip) state_d = ST_FAULT;
        else if (sup_present_o && standby_i && !ping_o) state_d = ST_SLEEP;
      end
      ST_FAULT: begin
        if (tmr_q == '0) state_d = ST_RUN;
      end
      ST_SLEEP: state_d = ST_SLEEP; // supply is about to be removed
      default: state_d = ST_STRAP;
    endcase
  end

  // ----------------------------------------------------------------------
  // state, timer, strap
  // ----------------------------------------------------------------------
  // state register
  always_ff @(posedge clk_i) begin
    if (!nrst_i) state_q <= ST_STRAP;
    else if (en_i) state_q <= state_d;
  end

  // fault hold and self ping timer
  always_ff @(posedge clk_i) begin
    if (!nrst_i) tmr_q <= '0;
    else if (en_i) begin
      if (state_d == ST_FAULT && state_q != ST_FAULT) tmr_q <= OC_LOAD;
      else if (state_d == ST_RUN && (state_q != ST_RUN || ping_due)) tmr_q <= PING_LOAD;
      else if (tmr_q != '0) tmr_q <= tmr_q - TMR_W'(1);
    end
  end

  // presence strap caught once after release
  always_ff @(posedge clk_i) begin
    if (!nrst_i) sup_present_o <= 1'b0;
    else if (en_i && state_q == ST_STRAP) sup_present_o <= strap_sup_i;
  end

  // ----------------------------------------------------------------------
  // supervisor link
  // ----------------------------------------------------------------------
  // firmware transfer, one word per handshake
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      fw_valid_o <= 1'b0;
      fw_idx_q <= '0;
      fw_data_o <= 8'h00;
    end else if (en_i) begin
      fw_valid_o <= (state_d == ST_BOOT);
      if (state_q != ST_BOOT) begin
        fw_idx_q <= '0;
        fw_data_o <= FW_IMAGE[0];
      end else if (fw_acc) begin
        fw_idx_q <= fw_idx_q + FW_IDX_W'(1);
        fw_data_o <= FW_IMAGE[fw_idx_q + FW_IDX_W'(1)];
      end
    end
  end

  // sleep request, ping pulse, ready level
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      sleep_req_o <= 1'b0;
      ping_o <= 1'b0;
      ready_o <= 1'b0;
    end else if (en_i) begin
      sleep_req_o <= (state_d == ST_SLEEP && state_q != ST_SLEEP);
      ping_o <= state_d == ST_RUN && (state_q != ST_RUN || ping_due);
      ready_o <= (state_d == ST_RUN);
    end
  end

  // retained charge state, mode and fault
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      charge_o <= CHARGE_RST;
      mode_o <= MODE_RST;
      fault_o <= 1'b0;
    end else if (en_i) begin
      fault_o <= (state_d == ST_FAULT);
      if (state_q == ST_RESTORE && ret_valid_i) begin
        charge_o <= ret_charge_i;
        mode_o <= ret_mode_i;
      end else if (state_q == ST_RUN) begin
        charge_o <= charge_i;
        mode_o <= mode_i;
      end
    end
  end

  // detection only with current monitoring fitted
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      parasitic_metal_detect_en_o <= 1'b0;
      foreign_object_detect_en_o <= 1'b0;
    end else if (en_i) begin
      parasitic_metal_detect_en_o <= pmd_req_i && cur_mon_present_i;
      foreign_object_detect_en_o <= fod_req_i && cur_mon_present_i;
    end
  end

  // ----------------------------------------------------------------------
  // power stages and feedback steering
  // ----------------------------------------------------------------------
  for (genvar c = 0; c < N_COILS; c++) begin : g_coil
    assign coil_oh[c] = (coil_i == 2'(c));
    // feedback chain follows the coil code, the stage also needs drive in run
    always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
        hb_en_o[c] <= 1'b0;
        fb_sel_o[c] <= 1'b0;
      end else if (en_i) begin
        hb_en_o[c] <= state_d == ST_RUN && drive_i && coil_oh[c];
        fb_sel_o[c] <= coil_oh[c];
      end
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  a_oc_trips_fault: assert property (
    en_i && state_q == ST_RUN && oc_trip |=> fault_o && hb_en_o == '0
  ) else $error("over-current did not halt transfer");
  a_fault_holds: assert property (
    fault_o && tmr_q != '0 |=> fault_o
  ) else $error("fault released before hold ended");
  a_detect_needs_mon: assert property (
    $past(en_i) && parasitic_metal_detect_en_o |-> $past(cur_mon_present_i)
  ) else $error("metal detect without monitor");
  a_strap_held: assert property (
    state_q != ST_STRAP |=> $stable(sup_present_o)
  ) else $error("presence changed after sampling");
  a_fw_needs_sup: assert property (
    fw_valid_o |-> sup_present_o && !ready_o
  ) else $error("firmware sent without supervisor");
  a_sleep_in_standby: assert property (
    sleep_req_o |-> sup_present_o && $past(standby_i) && !ping_o
  ) else $error("sleep request outside standby");
  a_wake_pings: assert property (
    $rose(ready_o) |-> ping_o
  ) else $error("no ping on wake");
  a_one_stage: assert property (
    $onehot0(hb_en_o)
  ) else $error("more than one stage driven");
  a_fb_follows: assert property (
    hb_en_o != '0 |-> fb_sel_o == hb_en_o
  ) else $error("feedback not from driven coil");
  a_restore_first: assert property (
    en_i && state_q == ST_RESTORE && !ret_valid_i |=> !ready_o && hb_en_o == '0
  ) else $error("resumed before restore");

  // sleep request leaves one idle cycle after the ping pulse
  c_fault: cover property (fault_o ##1 !fault_o);
  c_boot_done: cover property (fw_valid_o ##1 ready_o);
  c_sleep: cover property (ping_o ##2 sleep_req_o);
  c_restore_wait: cover property (state_q == ST_RESTORE ##1 state_q == ST_RESTORE);
endmodule : lps_seq

//--- verification/lps_sup_model.sv
// lps_sup_model: supervisor model taking firmware and returning kept state
module lps_sup_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // firmware stream
  input wire logic fw_valid_i,
  output logic fw_ready_o,
  output int words_o,
  // retained state, {fault, mode, charge}
  input wire logic [4:0] keep_i,
  output logic ret_valid_o,
  output logic [1:0] ret_charge_o,
  output logic [1:0] ret_mode_o,
  output logic ret_fault_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_q;
  // accept firmware with random stalls and count words
  always @(posedge clk_i) begin
    fw_ready_o <= nrst_i & 1'($urandom_range(1));
    if (!nrst_i)
      words_o <= 0;
    else if (fw_valid_i && fw_ready_o)
      words_o <= words_o + 1;
  end
  // kept state offered a few cycles after release, so the controller waits
  always @(posedge clk_i) begin
    if (!nrst_i)
      wait_q <= 0;
    else if (wait_q < 3)
      wait_q <= wait_q + 1;
  end
  // state kept across controller off periods
  assign ret_valid_o = (wait_q == 3);
  assign {ret_fault_o, ret_mode_o, ret_charge_o} = keep_i;
endmodule : lps_sup_model

//--- verification/low_power_supervisor_sequencer_tb.sv
// low_power_supervisor_sequencer_tb: self-checking bench of lps_seq
module low_power_supervisor_sequencer_tb import lps_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, nrst_i = 0, strap_sup_i, cold_start_i, cur_mon_present_i, oc_over_i;
  logic pmd_req_i, fod_req_i, standby_i, drive_i, fw_ready_i, ret_valid_i, ret_fault_i;
  logic en_i = 1;
  // shortened hold and ping counts for simulation
  localparam int OC_SIM = 20;
  localparam int PING_SIM = 30;
  logic [1:0] charge_i, mode_i, coil_i, ret_charge_i, ret_mode_i, charge_o, mode_o;
  logic parasitic_metal_detect_en_o, foreign_object_detect_en_o, fault_o, sup_present_o;
  logic fw_valid_o, sleep_req_o, ready_o, ping_o;
  logic [7:0] fw_data_o;
  logic [2:0] hb_en_o, fb_sel_o;
  logic [4:0] keep;
  int words, fail_count = 0, checks_done = 0, cyc = 0, n;
  // 200 MHz clock
  always #2.5 clk_i = ~clk_i;
  lps_seq #(.OC_HOLD_CYCLES(OC_SIM), .PING_CYCLES(PING_SIM)) DUT (.clk_i, .nrst_i, .en_i,
    .strap_sup_i, .cold_start_i, .cur_mon_present_i, .oc_over_i, .pmd_req_i, .fod_req_i,
    .parasitic_metal_detect_en_o, .foreign_object_detect_en_o, .fault_o, .sup_present_o,
    .fw_valid_o, .fw_data_o, .fw_ready_i, .sleep_req_o, .ret_valid_i, .ret_charge_i,
    .ret_mode_i, .ret_fault_i, .standby_i, .charge_i, .mode_i, .charge_o, .mode_o,
    .ready_o, .ping_o, .drive_i, .coil_i, .hb_en_o, .fb_sel_o);
  lps_sup_model sup (.clk_i, .nrst_i, .fw_valid_i(fw_valid_o), .fw_ready_o(fw_ready_i),
    .words_o(words), .keep_i(keep), .ret_valid_o(ret_valid_i), .ret_charge_o(ret_charge_i),
    .ret_mode_o(ret_mode_i), .ret_fault_o(ret_fault_i));
  // one-hot coil code, none for index 3
  function automatic logic [2:0] hot(logic [1:0] c);
    return (c < 2'h3) ? 3'h1 << c : 3'h0;
  endfunction : hot
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  // reset for 20 cycles with given straps
  task automatic boot(logic s, logic c);
    @(negedge clk_i);
    nrst_i = 0;
    strap_sup_i = s;
    cold_start_i = c;
    repeat (20) @(negedge clk_i);
    chk("rst out", 8'h0, {4'h0, ready_o, fault_o, fw_valid_o, sleep_req_o});
    nrst_i = 1;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (ready_o !== 1'b1 && fault_o !== 1'b1 && n < 300);
  endtask : boot
  // hang guard
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  // main sequence
  initial begin
    {strap_sup_i, cold_start_i, cur_mon_present_i, oc_over_i, pmd_req_i, fod_req_i} = '0;
    {standby_i, drive_i, charge_i, mode_i, coil_i, keep} = '0;
    void'($urandom(67));
    standby_i = 1;
    boot(1, 1);
    chk("words", 8'(FW_WORDS), 8'(words));
    chk("present", 8'h1, 8'(sup_present_o));
    chk("ping", 8'h1, 8'(ping_o));
    strap_sup_i = 0;
    // sleep request comes once the ping pulse has ended
    repeat (2) @(negedge clk_i);
    chk("sleep", 8'h1, 8'(sleep_req_o));
    chk("held", 8'h1, 8'(sup_present_o));
    // wakes restore kept state, last one with a kept fault
    for (int i = 0; i < 4; i++) begin
      keep = {i == 3, 4'($urandom)};
      boot(1, 0);
      chk("restore", 8'(keep), 8'({fault_o, mode_o, charge_o}));
    end
    keep = 5'h0;
    boot(0, 0);
    chk("absent", 8'h0, 8'(sup_present_o));
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (ping_o !== 1'b1 && n < 100);
    chk("ping gap", 8'(PING_SIM), 8'(n));
    {cur_mon_present_i, drive_i, oc_over_i} = 3'h7;
    @(negedge clk_i);
    oc_over_i = 0;
    chk("oc", 8'h10, 8'({fault_o, hb_en_o, ready_o}));
    n = 0;
    while (fault_o === 1'b1 && n < 100) begin
      @(negedge clk_i);
      n++;
    end
    chk("hold", 8'(OC_SIM), 8'(n));
    standby_i = 0;
    // random coils and detections, unused sense input kept grounded
    for (int i = 0; i < 80; i++) begin
      {drive_i, coil_i, pmd_req_i, fod_req_i, cur_mon_present_i} = 6'($urandom);
      oc_over_i = 1'b0;
      @(negedge clk_i);
      chk("fb", 8'(hot(coil_i)), 8'(fb_sel_o));
      chk("hb", 8'(drive_i ? hot(coil_i) : 3'h0), 8'(hb_en_o));
      chk("det", 8'({pmd_req_i, fod_req_i} & {2{cur_mon_present_i}}),
        8'({parasitic_metal_detect_en_o, foreign_object_detect_en_o}));
    end
    chk("no fault", 8'h0, 8'(fault_o));
    // clock enable low freezes the feedback select
    en_i = 0;
    coil_i = coil_i + 2'h1;
    repeat (3) @(negedge clk_i);
    chk("freeze", 8'(hot(coil_i - 2'h1)), 8'(fb_sel_o));
    en_i = 1;
    @(negedge clk_i);
    chk("thaw", 8'(hot(coil_i)), 8'(fb_sel_o));
    tally_and_finish();
  end
endmodule : low_power_supervisor_sequencer_tb
